// ### hdl/gyrsp_pkg.sv
// package: constants, register map and command layout for the gyro spi host
package gyrsp_pkg;

  // device register addresses
  localparam logic [5:0] ADDR_READY_SYNC = 6'h01;
  localparam logic [5:0] ADDR_RATE_OUT   = 6'h08;
  localparam logic [5:0] ADDR_TEMP_OUT   = 6'h0a;
  localparam logic [5:0] ADDR_RATE_SETUP = 6'h28;
  localparam logic [5:0] ADDR_TEMP_SETUP = 6'h2a;
  localparam logic [5:0] ADDR_RATE_CONV  = 6'h30;
  localparam logic [5:0] ADDR_TEMP_CONV  = 6'h32;
  localparam logic [5:0] ADDR_RESOLUTION = 6'h38;

  // command byte fields
  localparam int CMD_READ_BIT = 6;
  localparam logic [7:0] CMD_RATE_READ = 8'h48;
  localparam logic [7:0] CMD_TEMP_READ = 8'h4a;

  // bring-up values
  localparam logic [7:0] VAL_READY_SYNC  = 8'h38;
  localparam logic [7:0] VAL_CH_SETUP    = 8'h0a;
  localparam logic [7:0] VAL_CONV_TIME   = 8'h05;
  localparam logic [7:0] VAL_RES_24      = 8'h22;
  localparam logic [7:0] VAL_RES_16      = 8'h20;
  localparam int         RES_24_BIT      = 1;
  localparam int         SYNC_EN_BIT     = 0;
  localparam int         ALL_CH_BIT      = 3;

  // host control registers (software side)
  localparam logic [3:0] HREG_CTRL      = 4'h0;
  localparam logic [3:0] HREG_STATUS    = 4'h1;
  localparam logic [3:0] HREG_RATE      = 4'h2;
  localparam logic [3:0] HREG_TEMP      = 4'h3;
  localparam logic [3:0] HREG_RAW_CMD   = 4'h4;
  localparam logic [3:0] HREG_RAW_DATA  = 4'h5;
  localparam logic [3:0] HREG_CLKDIV    = 4'h6;
  localparam logic [3:0] HREG_COUNT     = 4'h7;

  // ctrl bits
  localparam int CTRL_INIT     = 0;
  localparam int CTRL_AUTO     = 1;
  localparam int CTRL_USE_TEMP = 2;
  localparam int CTRL_RES24    = 3;
  localparam int CTRL_SYNC_EN  = 4;
  localparam int CTRL_ALL_CH   = 5;
  localparam int CTRL_RAW_GO   = 6;
  localparam int CTRL_SYNC_OUT = 7;

  // timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int SYNC_MIN_NS   = 50;
  localparam int SYNC_MIN_CYC  = (SYNC_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] CLKDIV_RESET = 8'h04;
endpackage : gyrsp_pkg

// ### hdl/gyrsp_if.sv
// interface: byte engine carrier between sequencer and spi shifter
`timescale 1ns/1ps
interface gyrsp_if;
  logic       start;
  logic       last;
  logic [7:0] tx_byte;
  logic       done;
  logic [7:0] rx_byte;
  logic       busy;
  logic [7:0] half_div;

  modport master (output start, last, tx_byte, half_div, input done, rx_byte, busy);
  modport shifter (input start, last, tx_byte, half_div, output done, rx_byte, busy);
endinterface : gyrsp_if

// ### hdl/gyrsp_shift.sv
// module: spi mode-3 byte shifter with chip select handling
`timescale 1ns/1ps
module gyrsp_shift (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  gyrsp_if.shifter  bus,
  input  wire logic sdo_sync,
  output logic      sclk_reg,
  output logic      cs_n_reg,
  output logic      sdi_reg
);
  logic [7:0] div_cnt_reg;
  logic [7:0] sh_reg;
  logic [3:0] bit_cnt_reg;
  logic       active_reg;
  logic       last_reg;
  logic       done_reg;
  logic       tail_reg;
  wire        tick = active_reg && (div_cnt_reg == 8'h00);
  wire        byte_end = tick && sclk_reg == 1'b0 && bit_cnt_reg == 4'h7;

  assign bus.done    = done_reg;
  assign bus.rx_byte = sh_reg;
  assign bus.busy    = active_reg;

  // ==========================================================
  // divider and shift: data out on falling, sampled on rising
  always_ff @(posedge clk_sys) begin
    done_reg <= 1'b0;
    if (sys_rst) begin
      div_cnt_reg <= 8'h00;
      sh_reg      <= 8'h00;
      bit_cnt_reg <= 4'h0;
      active_reg  <= 1'b0;
      last_reg    <= 1'b0;
      tail_reg    <= 1'b0;
      sclk_reg    <= 1'b1;
      cs_n_reg    <= 1'b1;
      sdi_reg     <= 1'b0;
    end else if (bus.start && !active_reg) begin
      cs_n_reg    <= 1'b0;
      active_reg  <= 1'b1;
      last_reg    <= bus.last;
      sh_reg      <= bus.tx_byte;
      bit_cnt_reg <= 4'h0;
      div_cnt_reg <= bus.half_div;
    end else if (tick && tail_reg) begin
      // one half period with clock high before select rises
      tail_reg   <= 1'b0;
      active_reg <= 1'b0;
      done_reg   <= 1'b1;
      cs_n_reg   <= 1'b1;
    end else if (tick) begin
      div_cnt_reg <= bus.half_div;
      if (sclk_reg) begin
        sclk_reg <= 1'b0;
        sdi_reg  <= sh_reg[7];
      end else begin
        sclk_reg    <= 1'b1;
        sh_reg      <= {sh_reg[6:0], sdo_sync};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (byte_end && last_reg) begin
          tail_reg <= 1'b1;
        end else if (byte_end) begin
          active_reg <= 1'b0;
          done_reg   <= 1'b1;
        end
      end
    end else if (active_reg) begin
      div_cnt_reg <= div_cnt_reg - 8'h01;
    end
  end
endmodule : gyrsp_shift

// ### hdl/gyrsp_host.sv
// module: host controller that configures and reads the gyro over spi
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module gyrsp_host (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [31:0]     reg_rdata,
  output logic            spi_sclk,
  output logic            spi_cs_n,
  output logic            spi_sdi,
  input  wire logic       spi_sdo,
  input  wire logic       rdy_pin,
  output logic            sync_n_out
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_CMD  = 8'b0000_0010,
    ST_WAIT = 8'b0000_0100,
    ST_DATA = 8'b0000_1000,
    ST_NEXT = 8'b0001_0000,
    ST_DONE = 8'b0010_0000,
    ST_RDY  = 8'b0100_0000,
    ST_PAUSE = 8'b1000_0000
  } gyrsp_state_t;

  gyrsp_if eng ();

  logic [2:0]  sdo_pipe_reg;
  logic [2:0]  rdy_pipe_reg;
  logic        sdo_s_reg;
  logic        rdy_s_reg;
  gyrsp_state_t st_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  div_reg;
  logic [7:0]  raw_cmd_reg;
  logic [7:0]  raw_data_reg;
  logic [23:0] rate_reg;
  logic [23:0] temp_reg;
  logic [23:0] acc_reg;
  logic [15:0] count_reg;
  logic [3:0]  step_reg;
  logic [1:0]  left_reg;
  logic        is_read_reg;
  logic        is_raw_reg;
  logic        configured_reg;
  logic        busy_reg;
  logic        raw_pend_reg;
  logic        temp_turn_reg;
  logic        err_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  wval_reg;
  logic        start_reg;
  logic        last_reg;
  logic [7:0]  tx_reg;
  logic [31:0] rdata_reg;

  // ==========================================================
  // pin input synchronisers: change counts when stages 2 and 3 agree
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sdo_pipe_reg <= 3'h0;
      rdy_pipe_reg <= 3'h7;
      sdo_s_reg    <= 1'b0;
      rdy_s_reg    <= 1'b1;
    end else begin
      sdo_pipe_reg <= {sdo_pipe_reg[1:0], spi_sdo};
      rdy_pipe_reg <= {rdy_pipe_reg[1:0], rdy_pin};
      if (sdo_pipe_reg[1] == sdo_pipe_reg[2]) begin
        sdo_s_reg <= sdo_pipe_reg[2];
      end
      if (rdy_pipe_reg[1] == rdy_pipe_reg[2]) begin
        rdy_s_reg <= rdy_pipe_reg[2];
      end
    end
  end

  // ==========================================================
  // bring-up table
  function automatic logic [15:0] init_step(input logic [3:0] idx, input logic [7:0] c);
    logic [7:0] res;
    res = c[gyrsp_pkg::CTRL_RES24] ? gyrsp_pkg::VAL_RES_24 : gyrsp_pkg::VAL_RES_16;
    unique case (idx)
      // fixed nibble from the bring-up value, any/all and sync bits from ctrl
      4'h0: init_step = {2'b00, gyrsp_pkg::ADDR_READY_SYNC,
                         gyrsp_pkg::VAL_READY_SYNC[7:4],
                         c[gyrsp_pkg::CTRL_ALL_CH],
                         2'b00,
                         c[gyrsp_pkg::CTRL_SYNC_EN]};
      4'h1: init_step = {2'b00, gyrsp_pkg::ADDR_RATE_SETUP, gyrsp_pkg::VAL_CH_SETUP};
      4'h2: init_step = {2'b00, gyrsp_pkg::ADDR_RATE_CONV, gyrsp_pkg::VAL_CONV_TIME};
      4'h3: init_step = {2'b00, gyrsp_pkg::ADDR_TEMP_SETUP, gyrsp_pkg::VAL_CH_SETUP};
      4'h4: init_step = {2'b00, gyrsp_pkg::ADDR_TEMP_CONV, gyrsp_pkg::VAL_CONV_TIME};
      default: init_step = {2'b00, gyrsp_pkg::ADDR_RESOLUTION, res};
    endcase
  endfunction : init_step

  // the 3-flop sdo filter needs a half period of at least five cycles
  wire        div_ok = reg_wdata[7:0] >= gyrsp_pkg::CLKDIV_RESET;

  // data bytes of a read: 24-bit gives three, 16-bit two
  wire [1:0] data_bytes = ctrl_reg[gyrsp_pkg::CTRL_RES24] ? 2'd3 : 2'd2;
  wire [15:0] step_word = init_step(step_reg, ctrl_reg);
  wire        skip_temp = !ctrl_reg[gyrsp_pkg::CTRL_USE_TEMP] &&
                          (step_reg == 4'h3 || step_reg == 4'h4);
  wire        want_init = ctrl_reg[gyrsp_pkg::CTRL_INIT] && !configured_reg;
  wire        want_auto = ctrl_reg[gyrsp_pkg::CTRL_AUTO] && configured_reg && !rdy_s_reg;
  wire        sw_ctrl_wr = reg_wr && reg_addr == gyrsp_pkg::HREG_CTRL;
  wire [23:0] acc_shift = {acc_reg[15:0], eng.rx_byte};

  assign eng.start    = start_reg;
  assign eng.last     = last_reg;
  assign eng.tx_byte  = tx_reg;
  assign eng.half_div = div_reg;

  gyrsp_shift u_shift (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .bus      (eng.shifter),
    .sdo_sync (sdo_s_reg),
    .sclk_reg (spi_sclk),
    .cs_n_reg (spi_cs_n),
    .sdi_reg  (spi_sdi)
  );

  // ==========================================================
  // software registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg     <= 8'h8c;
      div_reg      <= gyrsp_pkg::CLKDIV_RESET;
      raw_cmd_reg  <= 8'h00;
      raw_pend_reg <= 1'b0;
      sync_n_out   <= 1'b1;
    end else begin
      if (sw_ctrl_wr) begin
        ctrl_reg   <= reg_wdata[7:0];
        sync_n_out <= reg_wdata[gyrsp_pkg::CTRL_SYNC_OUT];
      end
      if (reg_wr && reg_addr == gyrsp_pkg::HREG_CLKDIV && div_ok) begin
        div_reg <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == gyrsp_pkg::HREG_RAW_CMD) begin
        raw_cmd_reg <= {1'b0, reg_wdata[6:0]};
      end
      if (reg_wr && reg_addr == gyrsp_pkg::HREG_RAW_DATA) begin
        raw_data_reg <= reg_wdata[7:0];
      end
      if (sw_ctrl_wr && reg_wdata[gyrsp_pkg::CTRL_RAW_GO]) begin
        raw_pend_reg <= 1'b1;
      end else if (st_reg == ST_IDLE && raw_pend_reg && configured_reg) begin
        raw_pend_reg <= 1'b0;
      end
    end
  end

  wire [31:0] status_word = {20'h0, err_reg, temp_turn_reg, rdy_s_reg,
                             configured_reg, busy_reg, raw_pend_reg, 6'h0};
  wire [31:0] rd_mux =
    reg_addr == gyrsp_pkg::HREG_CTRL     ? {24'h0, ctrl_reg} :
    reg_addr == gyrsp_pkg::HREG_STATUS   ? status_word :
    reg_addr == gyrsp_pkg::HREG_RATE     ? {8'h0, rate_reg} :
    reg_addr == gyrsp_pkg::HREG_TEMP     ? {8'h0, temp_reg} :
    reg_addr == gyrsp_pkg::HREG_RAW_CMD  ? {24'h0, raw_cmd_reg} :
    reg_addr == gyrsp_pkg::HREG_RAW_DATA ? {24'h0, raw_data_reg} :
    reg_addr == gyrsp_pkg::HREG_CLKDIV   ? {24'h0, div_reg} :
    reg_addr == gyrsp_pkg::HREG_COUNT    ? {16'h0, count_reg} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // transaction sequencer
  always_ff @(posedge clk_sys) begin
    start_reg <= 1'b0;
    if (sys_rst) begin
      st_reg         <= ST_IDLE;
      step_reg       <= 4'h0;
      left_reg       <= 2'd0;
      is_read_reg    <= 1'b0;
      is_raw_reg     <= 1'b0;
      configured_reg <= 1'b0;
      busy_reg       <= 1'b0;
      temp_turn_reg  <= 1'b0;
      err_reg        <= 1'b0;
      cmd_reg        <= 8'h00;
      wval_reg       <= 8'h00;
      last_reg       <= 1'b0;
      tx_reg         <= 8'h00;
      acc_reg        <= 24'h0;
      rate_reg       <= 24'h0;
      temp_reg       <= 24'h0;
      count_reg      <= 16'h0;
    end else begin
      if (sw_ctrl_wr && reg_wdata[gyrsp_pkg::CTRL_INIT] == 1'b0) begin
        configured_reg <= 1'b0;
      end
      unique case (st_reg)
        ST_IDLE: begin
          busy_reg <= 1'b0;
          if (want_init) begin
            if (skip_temp) begin
              step_reg <= step_reg + 4'h1;
            end else begin
              cmd_reg     <= {2'b00, step_word[13:8]};
              wval_reg    <= step_word[7:0];
              is_read_reg <= 1'b0;
              is_raw_reg  <= 1'b0;
              st_reg      <= ST_CMD;
            end
          end else if (raw_pend_reg && configured_reg) begin
            cmd_reg     <= raw_cmd_reg;
            wval_reg    <= raw_data_reg;
            is_read_reg <= raw_cmd_reg[gyrsp_pkg::CMD_READ_BIT];
            is_raw_reg  <= 1'b1;
            st_reg      <= ST_CMD;
          end else if (want_auto) begin
            cmd_reg <= (temp_turn_reg && ctrl_reg[gyrsp_pkg::CTRL_USE_TEMP]) ?
                       gyrsp_pkg::CMD_TEMP_READ : gyrsp_pkg::CMD_RATE_READ;
            is_read_reg <= 1'b1;
            is_raw_reg  <= 1'b0;
            st_reg      <= ST_CMD;
          end
        end
        ST_CMD: begin
          busy_reg  <= 1'b1;
          tx_reg    <= cmd_reg;
          last_reg  <= 1'b0;
          start_reg <= 1'b1;
          left_reg  <= is_read_reg ? data_bytes : 2'd1;
          acc_reg   <= 24'h0;
          st_reg    <= ST_WAIT;
        end
        ST_WAIT: begin
          // command byte still shifting
          if (eng.done) begin
            st_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          // reads send zero filler while the device answers
          tx_reg    <= is_read_reg ? 8'h00 : wval_reg;
          last_reg  <= left_reg == 2'd1;
          start_reg <= 1'b1;
          st_reg    <= ST_NEXT;
        end
        ST_NEXT: begin
          if (eng.done) begin
            acc_reg  <= acc_shift;
            left_reg <= left_reg - 2'd1;
            st_reg   <= (left_reg == 2'd1) ? ST_DONE : ST_DATA;
          end
        end
        ST_DONE: begin
          if (is_raw_reg) begin
            if (is_read_reg) begin
              rate_reg <= (cmd_reg[5:0] == gyrsp_pkg::ADDR_RATE_OUT) ? acc_reg : rate_reg;
              temp_reg <= (cmd_reg[5:0] == gyrsp_pkg::ADDR_TEMP_OUT) ? acc_reg : temp_reg;
            end
          end else if (is_read_reg) begin
            if (cmd_reg == gyrsp_pkg::CMD_TEMP_READ) begin
              temp_reg <= acc_reg;
            end else begin
              rate_reg <= acc_reg;
            end
            count_reg     <= count_reg + 16'h1;
            temp_turn_reg <= !temp_turn_reg;
          end else begin
            step_reg <= step_reg + 4'h1;
            if (step_reg == 4'h5) begin
              configured_reg <= 1'b1;
              step_reg       <= 4'h0;
            end
          end
          st_reg <= is_read_reg && !is_raw_reg ? ST_RDY : ST_PAUSE;
        end
        ST_RDY: begin
          // device raises data-ready after a read; move on when it is high or the shifter is idle, stay and flag an error while it is low and the shifter is busy
          if (rdy_s_reg) begin
            st_reg <= ST_PAUSE;
          end else if (eng.busy) begin
            err_reg <= 1'b1;
          end else begin
            st_reg <= ST_PAUSE;
          end
        end
        ST_PAUSE: begin
          // let the shifter release select before the next frame
          if (!eng.busy) begin
            st_reg <= ST_IDLE;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : gyrsp_host

// ### dv/gyrsp_checker.sv
// checker: port-level assertions for the gyro spi host
`timescale 1ns/1ps
module gyrsp_checker (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        spi_sclk,
  input wire logic        spi_cs_n,
  input wire logic        spi_sdi,
  input wire logic        spi_sdo,
  input wire logic        rdy_pin,
  input wire logic        sync_n_out
);
  // ==========
  // frame tracking
  logic       sclk_q;
  logic [5:0] bit_cnt;
  logic [7:0] cmd_sh;
  logic       sync_exp;
  wire        rise = spi_sclk & ~sclk_q & ~spi_cs_n;
  wire        in_cmd = rise & (bit_cnt < 6'h08);
  wire        ctrl_wr = reg_wr & (reg_addr == gyrsp_pkg::HREG_CTRL);

  always_ff @(posedge clk_sys) begin
    sclk_q   <= sys_rst | spi_sclk;
    bit_cnt  <= spi_cs_n ? 6'h00 : bit_cnt + {5'h00, rise};
    cmd_sh   <= in_cmd ? {cmd_sh[6:0], spi_sdi} : cmd_sh;
    sync_exp <= sys_rst | (ctrl_wr ? reg_wdata[7] : sync_exp);
  end

  // ==========
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_first_bit;
    rise && bit_cnt == 6'h00;
  endsequence
  sequence s_frame_end;
    $rose(spi_cs_n);
  endsequence

  chk_cmd_msb_zero: assert property (s_first_bit |-> !spi_sdi)
    else $error("command bit 7 not zero");
  chk_whole_bytes: assert property (s_frame_end |-> bit_cnt[2:0] == 3'h0 && bit_cnt != 6'h00)
    else $error("frame not whole bytes");
  chk_frame_len: assert property (s_frame_end |-> (cmd_sh[6] ?
    bit_cnt inside {6'h10, 6'h18, 6'h20} : bit_cnt == 6'h10))
    else $error("frame length wrong for direction");
  chk_data_cmd: assert property ((s_frame_end and (bit_cnt > 6'h10)) |->
    cmd_sh inside {8'h48, 8'h4a})
    else $error("multi-byte read with wrong command");
  chk_cs_idle_clk: assert property ($fell(spi_cs_n) |-> spi_sclk)
    else $error("chip select fell with clock low");
  chk_sdi_hold: assert property (rise |-> $stable(spi_sdi) ##1 $stable(spi_sdi))
    else $error("data moved at clock rise");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  chk_unmapped_zero: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_sync_follow: assert property (ctrl_wr |-> ##[1:2] sync_n_out == sync_exp)
    else $error("hold output does not follow control");
  chk_reset_idle: assert property ($fell(sys_rst) |-> spi_cs_n && spi_sclk && sync_n_out)
    else $error("outputs not idle after reset");
endmodule : gyrsp_checker

bind gyrsp_host gyrsp_checker i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spi_sclk(spi_sclk),
  .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .rdy_pin(rdy_pin),
  .sync_n_out(sync_n_out));

// ### dv/gyrsp_dev_model.sv
// model: behavioural spi gyro device with register map and conversions
`timescale 1ns/1ps
module gyrsp_dev_model #(
  parameter int UPD_NS   = 87719,
  parameter int PULSE_NS = 26000
) (
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  input  wire logic spi_sdi,
  output logic      spi_sdo,
  output logic      rdy_pin,
  input  wire logic sync_n
);
  logic [7:0]  regs [0:63];
  logic [7:0]  shin;
  logic [7:0]  cmd;
  logic [31:0] tx;
  logic [23:0] rate_val = 24'h123456;
  logic [23:0] temp_val = 24'h800000;
  logic [23:0] last_rate;
  logic [23:0] last_temp;
  logic [5:0]  wlog [$];
  logic        run = 1'b0;
  logic        nxt_temp = 1'b0;
  logic        new_rate = 1'b0;
  logic        new_temp = 1'b0;
  logic        pulse = 1'b0;
  event        upd_ev;
  int          nbit = 0;
  int          n_upd = 0;
  wire         res24 = regs[6'h38][1];
  wire         temp_on = regs[6'h2a][3];

  initial begin
    spi_sdo = 1'b1;
    foreach (regs[i]) regs[i] = 8'h00;
  end

  // ==========
  // ready: all channels or any channel
  assign rdy_pin = pulse || (regs[6'h01][3] ? !(new_rate && (new_temp || !temp_on)) :
                   !(new_rate || new_temp));

  // high pulse after every update, so an unread stream still toggles
  always @(upd_ev) begin
    pulse = 1'b1;
    #(PULSE_NS);
    pulse = 1'b0;
  end

  // ==========
  // serial port
  always @(negedge spi_cs_n) nbit = 0;
  always @(posedge spi_cs_n) spi_sdo = ~spi_sdo;
  always @(posedge spi_sclk) if (!spi_cs_n) begin
    shin = {shin[6:0], spi_sdi};
    nbit++;
    if (nbit == 8) cmd = shin;
    if (nbit == 16 && !cmd[6] && !(cmd[5:0] inside {6'h00, 6'h08, 6'h0a})) begin
      regs[cmd[5:0]] = shin;
      wlog.push_back(cmd[5:0]);
      if (cmd[5:0] == 6'h38) begin
        run = 1'b1;
        nxt_temp = 1'b0;
      end
    end
  end
  always @(negedge spi_sclk) if (!spi_cs_n) begin
    if (nbit == 8) begin
      tx = {regs[cmd[5:0]], 24'h0};
      if (cmd[5:0] == 6'h08) tx = res24 ? {rate_val, 8'h0} : {rate_val[23:8], 16'h0};
      if (cmd[5:0] == 6'h0a) tx = res24 ? {temp_val, 8'h0} : {temp_val[23:8], 16'h0};
      if (cmd[5:0] == 6'h08) last_rate = res24 ? tx[31:8] : tx[31:8] >> 8;
      if (cmd[5:0] == 6'h0a) last_temp = res24 ? tx[31:8] : tx[31:8] >> 8;
      if (cmd[6] && cmd[5:0] inside {6'h08, 6'h0a}) begin
        new_rate = 1'b0;
        new_temp = 1'b0;
      end
    end
    spi_sdo = tx[31];
    tx = tx << 1;
  end

  // ==========
  // free-running conversions, rate then temperature
  always begin
    #(UPD_NS);
    if (run && !(regs[6'h01][0] && !sync_n)) begin
      n_upd++;
      -> upd_ev;
      if (spi_cs_n && nxt_temp) begin
        temp_val = temp_val + 24'h010101;
        new_temp = 1'b1;
      end else if (spi_cs_n) begin
        rate_val = rate_val + 24'h111111;
        new_rate = 1'b1;
      end
      nxt_temp = !nxt_temp && temp_on;
    end
  end
endmodule : gyrsp_dev_model

// ### dv/gyrsp_host_tb.sv
// testbench: gyro spi host against the behavioural device model
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module gyrsp_host_tb;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        spi_sclk, spi_cs_n, spi_sdi, spi_sdo, rdy_pin, sync_n_out;
  logic [31:0] rd_val;
  int          num_errors = 0;
  int          n_compared = 0;
  int          n0;
  logic [5:0]  cfg_a [6] = '{6'h01, 6'h28, 6'h30, 6'h2a, 6'h32, 6'h38};
  logic [7:0]  cfg_v [6] = '{8'h38, 8'h0a, 8'h05, 8'h0a, 8'h05, 8'h22};

  always #10 clk_sys = ~clk_sys;

  gyrsp_host i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .rdy_pin(rdy_pin), .sync_n_out(sync_n_out));
  gyrsp_dev_model #(.UPD_NS(20000), .PULSE_NS(6000))
    i_dev (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .rdy_pin(rdy_pin), .sync_n(sync_n_out));

  // ==========
  // bus tasks
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= {24'h0, d};
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    rd(gyrsp_pkg::HREG_STATUS, rd_val);
    while (rd_val[b] !== v && n < 5000) begin
      rd(gyrsp_pkg::HREG_STATUS, rd_val);
      n++;
    end
    if (rd_val[b] !== v) begin
      num_errors++;
      $display("mismatch status bit %0d never reached %b", b, v);
      give_verdict();
    end
  endtask : wait_stat

  task automatic bring_up(input logic [7:0] c);
    wr(gyrsp_pkg::HREG_CTRL, c & 8'hfe);
    wr(gyrsp_pkg::HREG_CTRL, c);
    wait_stat(8, 1'b1);
  endtask : bring_up

  task automatic run_auto(input logic [7:0] c);
    logic [31:0] c0;
    int          n;
    rd(gyrsp_pkg::HREG_COUNT, c0);
    wr(gyrsp_pkg::HREG_CTRL, c | 8'h02);
    n = 0;
    rd_val = c0;
    while (rd_val < c0 + 3 && n < 5000) begin
      rd(gyrsp_pkg::HREG_COUNT, rd_val);
      n++;
    end
    `CHK("auto reads", 1'b1, n < 5000)
    wr(gyrsp_pkg::HREG_CTRL, c);
    wait_stat(7, 1'b0);
    rd(gyrsp_pkg::HREG_RATE, rd_val);
    `CHK("rate data", {8'h0, i_dev.last_rate}, rd_val)
    rd(gyrsp_pkg::HREG_TEMP, rd_val);
    `CHK("temp data", {8'h0, i_dev.last_temp}, rd_val)
  endtask : run_auto

  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    `CHK("hold output", 1'b1, sync_n_out)
    rd(gyrsp_pkg::HREG_CTRL, rd_val);
    `CHK("ctrl reset", 32'h0000008c, rd_val)
    rd(gyrsp_pkg::HREG_CLKDIV, rd_val);
    `CHK("clkdiv reset", 32'h00000004, rd_val)
    wr(4'hf, 8'hff);
    rd(4'hf, rd_val);
    `CHK("unmapped", 32'h0, rd_val)
    bring_up(8'had);
    `CHK("write count", 6, i_dev.wlog.size())
    for (int i = 0; i < 6; i++) begin
      `CHK("write order", cfg_a[i], i_dev.wlog[i])
      `CHK("device reg", cfg_v[i], i_dev.regs[cfg_a[i]])
    end
    `CHK("converting", 1'b1, i_dev.run)
    run_auto(8'had);
    bring_up(8'ha5);
    `CHK("res 16", 8'h20, i_dev.regs[6'h38])
    run_auto(8'ha5);
    i_dev.regs[6'h2a] = 8'h00;
    i_dev.wlog.delete();
    bring_up(8'h89);
    `CHK("no temp writes", 4, i_dev.wlog.size())
    `CHK("temp setup", 8'h00, i_dev.regs[6'h2a])
    `CHK("any ready", 8'h30, i_dev.regs[6'h01])
    bring_up(8'h3d);
    `CHK("sync reg", 8'h39, i_dev.regs[6'h01])
    `CHK("hold low", 1'b0, sync_n_out)
    n0 = i_dev.n_upd;
    repeat (3000) @(posedge clk_sys);
    `CHK("held", n0, i_dev.n_upd)
    wr(gyrsp_pkg::HREG_CTRL, 8'hbd);
    repeat (3000) @(posedge clk_sys);
    `CHK("resumed", 1'b1, i_dev.n_upd > n0)
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    `CHK("select idle", 1'b1, spi_cs_n)
    give_verdict();
  end
endmodule : gyrsp_host_tb
